//--- verilog/rssd_top.sv
// rssd_top: reset source merge, start-up delay, register slave
// assumes async detector pins and a free-running system clock
//
// The register offsets and the Avalon-MM register port were left to the implementer.
module rssd_top #(
  parameter int CK_LONG_CYC = rssd_pkg::CK_LONG,    // 16K clock part
  parameter int RT_LO_LONG  = rssd_pkg::RT_LO_LONG, // long real part, low level
  parameter int RT_HI_LONG  = rssd_pkg::RT_HI_LONG, // long real part, high level
  parameter int BOD_LO_CYC  = rssd_pkg::BOD_LO_CYC  // 21 us filter
) (
  input  wire logic        clk,             // system clock
  input  wire logic        rst,             // async reset, high
  input  wire logic        clk_en,          // freezes all state when low
  input  wire logic        power_ok,        // above power-on threshold
  input  wire logic        ext_reset_n,     // reset pin, low active
  input  wire logic        bod_below,       // supply below trigger
  input  wire logic        wdt_osc,         // watchdog oscillator
  input  wire logic        wdt_timeout,     // watchdog expiry strobe
  input  wire logic        wake_req,        // wake from sleep strobe
  input  wire logic [3:0]  avs_address,     // byte address
  input  wire logic        avs_read,        // read request
  input  wire logic        avs_write,       // write request
  input  wire logic [31:0] avs_writedata,   // write data
  input  wire logic [3:0]  avs_byteenable,  // byte lanes
  output logic      [31:0] avs_readdata,    // read data
  output logic             avs_waitrequest, // stall
  output logic             core_reset,      // core held in reset
  output logic             io_init,         // load I/O initial values
  output logic             core_stall,      // wake delay running
  output logic             fetch_start,     // release pulse
  output logic      [15:0] boot_addr        // first fetch address
);

  typedef struct packed {
    logic                       por_s1;
    logic                       por_s2;
    logic                       ext_s1;
    logic                       ext_s2;
    logic                       bod_s1;
    logic                       bod_s2;
    logic                       osc_s1;
    logic                       osc_s2;
    logic                       osc_s3;
    logic [rssd_pkg::EXT_W-1:0] ext_cnt;
    logic [rssd_pkg::BOD_W-1:0] bod_cnt;
    logic                       wdt_prev;
    logic                       wdt_pulse;
    rssd_pkg::rssd_state_e      fsm;
    logic [rssd_pkg::CNT_W-1:0] cnt;
    logic                       core_rst;
    logic                       stall;
    logic                       fetch;
    logic [2:0]                 sel;
    logic                       lvl;
    logic                       brownout_enable_fuse;
    logic                       wdten;
    logic                       ack;
    logic [31:0]                rdata;
  } rssd_regs_s;

  // fuses come up delivered; core starts in reset
  // pin stages reset to the idle high level, so no false low follows reset
  localparam rssd_regs_s RST_VAL = '{
    ext_s1:   1'b1,
    ext_s2:   1'b1,
    fsm:      rssd_pkg::ST_HOLD,
    core_rst: 1'b1,
    sel:      rssd_pkg::SEL_RESET,
    default:  '0
  };

  rssd_regs_s                 st;
  rssd_regs_s                 nx;
  logic                       src_por;
  logic                       src_ext;
  logic                       src_wdt;
  logic                       src_bod;
  logic                       any_src;
  logic                       tick;
  logic                       req;
  logic [rssd_pkg::CNT_W-1:0] rt_tgt;
  logic [rssd_pkg::CNT_W-1:0] ck_tgt;
  logic [rssd_pkg::BOD_W-1:0] bod_tgt;
  logic [31:0]                rd;

  // reset sources, all taken from synchronised flops
  assign src_por = ~st.por_s2;
  assign src_ext = st.ext_cnt == rssd_pkg::EXT_W'(rssd_pkg::EXT_FLT_CYC);
  assign src_wdt = st.wdt_pulse;
  // RQ12 gated by enable fuse
  assign src_bod = st.brownout_enable_fuse & (st.bod_cnt >= bod_tgt);
  // RQ1 merge of four sources
  assign any_src = src_por | src_ext | src_wdt | src_bod;
  // one watchdog oscillator period per rising edge
  assign tick    = st.osc_s2 & ~st.osc_s3;
  assign req     = avs_read | avs_write;

  // RQ14 level fuse picks the filter length
  always_comb begin
    if (st.lvl) begin
      bod_tgt = rssd_pkg::BOD_W'(rssd_pkg::BOD_HI_CYC);
    end else begin
      bod_tgt = rssd_pkg::BOD_W'(BOD_LO_CYC);
    end
  end

  // RQ7 real-time part; RQ16 level fuse used regardless
  always_comb begin
    unique case (st.sel)
      3'h0, 3'h3, 3'h6: begin
        rt_tgt = st.lvl ? rssd_pkg::CNT_W'(rssd_pkg::RT_HI_SHORT)
                        : rssd_pkg::CNT_W'(rssd_pkg::RT_LO_SHORT);
      end
      3'h2, 3'h5: begin
        rt_tgt = st.lvl ? rssd_pkg::CNT_W'(RT_HI_LONG)
                        : rssd_pkg::CNT_W'(RT_LO_LONG);
      end
      3'h1, 3'h4, 3'h7: begin
        rt_tgt = rssd_pkg::CNT_W'(rssd_pkg::RT_BOD);
      end
    endcase
  end

  // RQ6 clock-count part from the select code
  always_comb begin
    unique case (st.sel)
      3'h0, 3'h1: begin
        ck_tgt = rssd_pkg::CNT_W'(rssd_pkg::CK_SHORT);
      end
      3'h2, 3'h3, 3'h4: begin
        ck_tgt = rssd_pkg::CNT_W'(CK_LONG_CYC);
      end
      3'h5, 3'h6, 3'h7: begin
        ck_tgt = rssd_pkg::CNT_W'(rssd_pkg::CK_MID);
      end
    endcase
  end

  // next state of every flop in the block
  always_comb begin
    nx = st;
    rd = '0;
    // two-flop synchronisers, first stage feeds only the second
    nx.por_s1 = power_ok;
    nx.por_s2 = st.por_s1;
    nx.ext_s1 = ext_reset_n;
    nx.ext_s2 = st.ext_s1;
    nx.bod_s1 = bod_below;
    nx.bod_s2 = st.bod_s1;
    nx.osc_s1 = wdt_osc;
    nx.osc_s2 = st.osc_s1;
    nx.osc_s3 = st.osc_s2;

    // RQ2 pin low filter, saturates at threshold
    if (st.ext_s2) begin
      nx.ext_cnt = '0;
    end else if (!src_ext) begin
      nx.ext_cnt = st.ext_cnt + 1'b1;
    end

    // RQ15 brown-out persistence filter
    if (!st.bod_s2 || !st.brownout_enable_fuse) begin
      nx.bod_cnt = '0;
    end else if (st.bod_cnt < bod_tgt) begin
      nx.bod_cnt = st.bod_cnt + 1'b1;
    end

    // RQ4 expiry counts only when enabled
    nx.wdt_prev  = wdt_timeout;
    // RQ17 edge detect gives a one-clock pulse
    nx.wdt_pulse = st.wdten & wdt_timeout & ~st.wdt_prev;

    // release sequence: real-time part, then clock part
    nx.fetch = 1'b0;
    unique case (st.fsm)
      rssd_pkg::ST_HOLD: begin
        // RQ9 sources gone, start real-time part
        nx.fsm = rssd_pkg::ST_REAL;
        nx.cnt = '0;
      end
      rssd_pkg::ST_REAL: begin
        if (tick) begin
          if (st.cnt == rt_tgt - 1'b1) begin
            nx.fsm = rssd_pkg::ST_CLOCK;
            nx.cnt = '0;
          end else begin
            nx.cnt = st.cnt + 1'b1;
          end
        end
      end
      rssd_pkg::ST_CLOCK: begin
        if (st.cnt == ck_tgt - 1'b1) begin
          // RQ5 release, fetch from address zero
          nx.fsm   = rssd_pkg::ST_RUN;
          nx.cnt   = '0;
          nx.fetch = 1'b1;
        end else begin
          nx.cnt = st.cnt + 1'b1;
        end
      end
      rssd_pkg::ST_RUN: begin
        // RQ8 wake skips the real-time part
        if (wake_req) begin
          nx.fsm = rssd_pkg::ST_WAKE;
          nx.cnt = '0;
        end
      end
      rssd_pkg::ST_WAKE: begin
        if (st.cnt == ck_tgt - 1'b1) begin
          nx.fsm = rssd_pkg::ST_RUN;
          nx.cnt = '0;
        end else begin
          nx.cnt = st.cnt + 1'b1;
        end
      end
    endcase

    // RQ20 any source restarts and clears the delay
    // covers RQ10, RQ11, RQ13, RQ18 release on the last source
    if (any_src) begin
      nx.fsm   = rssd_pkg::ST_HOLD;
      nx.cnt   = '0;
      nx.fetch = 1'b0;
    end
    nx.core_rst = (nx.fsm == rssd_pkg::ST_HOLD)
                | (nx.fsm == rssd_pkg::ST_REAL)
                | (nx.fsm == rssd_pkg::ST_CLOCK);
    nx.stall    = nx.fsm == rssd_pkg::ST_WAKE;

    // register slave: data captured on the waiting cycle
    nx.ack = req & ~st.ack;
    if (avs_address == rssd_pkg::CTRL_OFS) begin
      rd[rssd_pkg::CTRL_SEL_LSB +: 3] = st.sel;
      rd[rssd_pkg::CTRL_LVL]          = st.lvl;
      rd[rssd_pkg::CTRL_BOD]          = st.brownout_enable_fuse;
      rd[rssd_pkg::CTRL_WDT]          = st.wdten;
    end else if (avs_address == rssd_pkg::STAT_OFS) begin
      rd[rssd_pkg::STAT_RST]          = st.core_rst;
      rd[rssd_pkg::STAT_STALL]        = st.stall;
      rd[rssd_pkg::STAT_FSM_LSB +: 3] = st.fsm;
      rd[rssd_pkg::STAT_POR]          = src_por;
      rd[rssd_pkg::STAT_EXT]          = src_ext;
      rd[rssd_pkg::STAT_WDT]          = src_wdt;
      rd[rssd_pkg::STAT_BOD]          = src_bod;
    end
    if (avs_read && !st.ack) begin
      nx.rdata = rd;
    end
    // writes land on the completing edge only; byte 0 holds all bits
    if (avs_write && st.ack && avs_byteenable[0]
        && avs_address == rssd_pkg::CTRL_OFS) begin
      nx.sel   = avs_writedata[rssd_pkg::CTRL_SEL_LSB +: 3];
      nx.lvl   = avs_writedata[rssd_pkg::CTRL_LVL];
      nx.brownout_enable_fuse = avs_writedata[rssd_pkg::CTRL_BOD];
      nx.wdten = avs_writedata[rssd_pkg::CTRL_WDT];
    end
  end

  // single state register, frozen while clk_en is low
  // RQ19 select code resets to its delivered value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= RST_VAL;
    end else if (clk_en) begin
      st <= nx;
    end
  end

  // waitrequest drops only on an edge that will really advance
  assign avs_waitrequest = req & ~(st.ack & clk_en);
  assign avs_readdata    = st.rdata;
  assign core_reset      = st.core_rst;
  // RQ5 I/O registers load while reset is held
  assign io_init         = st.core_rst;
  assign core_stall      = st.stall;
  assign fetch_start     = st.fetch;
  assign boot_addr       = rssd_pkg::BOOT_ADDR;

  // checks on the sequencer
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_src_hold: assert property ( // RQ1
    clk_en && any_src |=> st.fsm == rssd_pkg::ST_HOLD && core_reset)
    else $error("source did not hold reset");

  chk_ext_filter: assert property ( // RQ2
    clk_en && !st.ext_s2
    && st.ext_cnt == rssd_pkg::EXT_W'(rssd_pkg::EXT_FLT_CYC - 1)
    |=> src_ext)
    else $error("long pin low did not reset");

  chk_ext_release: assert property ( // RQ11
    clk_en && st.ext_s2 |=> !src_ext)
    else $error("pin high kept reset source");

  chk_wdt_gate: assert property ( // RQ4
    st.wdt_pulse |-> $past(st.wdten))
    else $error("watchdog reset while disabled");

  chk_wdt_width: assert property ( // RQ17
    clk_en && st.wdt_pulse |=> !st.wdt_pulse)
    else $error("watchdog pulse longer than one clock");

  chk_fetch_zero: assert property ( // RQ5
    st.fetch && $past(clk_en)
    |-> !core_reset && $past(st.core_rst) && boot_addr == 16'h0000)
    else $error("bad release or boot address");

  chk_hold_clear: assert property ( // RQ20
    st.fsm == rssd_pkg::ST_HOLD |-> st.cnt == '0)
    else $error("delay counter not cleared");

  chk_clock_part: assert property ( // RQ6
    clk_en && st.fsm == rssd_pkg::ST_CLOCK && !any_src
    && st.cnt == ck_tgt - 1'b1 |=> st.fsm == rssd_pkg::ST_RUN)
    else $error("clock part length wrong");

  chk_real_part: assert property ( // RQ7
    clk_en && st.fsm == rssd_pkg::ST_REAL && tick && !any_src
    && st.cnt == rt_tgt - 1'b1 |=> st.fsm == rssd_pkg::ST_CLOCK)
    else $error("real-time part length wrong");

  chk_wake_skip: assert property ( // RQ8
    clk_en && st.fsm == rssd_pkg::ST_RUN && wake_req && !any_src
    |=> st.fsm == rssd_pkg::ST_WAKE && !core_reset)
    else $error("wake did not skip real part");

  chk_por_fast: assert property ( // RQ10
    clk_en && src_por |=> core_reset && st.cnt == '0)
    else $error("power loss not immediate");

  chk_bod_gate: assert property ( // RQ12
    !st.brownout_enable_fuse |-> !src_bod)
    else $error("brown-out reset while disabled");

  // brown-out filter: persistence sets the source, a gap clears it
  chk_bod_fast: assert property ( // RQ12
    clk_en && st.brownout_enable_fuse && st.bod_s2 && !avs_write
    && st.bod_cnt == bod_tgt - 1'b1 |=> src_bod)
    else $error("brown-out not taken after filter");

  chk_bod_filter: assert property ( // RQ15
    clk_en && !st.bod_s2 |=> !src_bod)
    else $error("short brown-out kept reset source");

  // release starts the cycle after the last source falls
  chk_hold_exit: assert property ( // RQ18
    clk_en && st.fsm == rssd_pkg::ST_HOLD && !any_src |=> st.fsm == rssd_pkg::ST_REAL)
    else $error("delay did not start after sources cleared");

  chk_wake_nofetch: assert property ( // RQ8
    clk_en && st.fsm == rssd_pkg::ST_WAKE && !any_src
    && st.cnt == ck_tgt - 1'b1 |=> st.fsm == rssd_pkg::ST_RUN && !fetch_start)
    else $error("wake end wrong or gave a fetch pulse");

  chk_sel_reset: assert property ( // RQ19
    $fell(rst) |-> st.sel == rssd_pkg::SEL_RESET && core_reset)
    else $error("select code not delivered value after reset");

  // bus: at least one wait state, writes land on the completing edge
  chk_bus_wait: assert property (
    req && !st.ack |-> avs_waitrequest)
    else $error("bus answered without a wait state");

  chk_write_lands: assert property (
    avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == rssd_pkg::CTRL_OFS
    |=> st.sel == $past(avs_writedata[2:0]) && st.brownout_enable_fuse == $past(avs_writedata[rssd_pkg::CTRL_BOD]))
    else $error("control write did not land");

  cov_release: cover property (st.fsm == rssd_pkg::ST_CLOCK ##1 st.fetch);
  cov_wake: cover property (st.fsm == rssd_pkg::ST_WAKE ##1 st.fsm == rssd_pkg::ST_RUN);
  cov_wdt: cover property (st.wdt_pulse ##1 st.fsm == rssd_pkg::ST_HOLD);
  cov_bod: cover property (src_bod);
  cov_ext: cover property (src_ext ##1 core_reset);

endmodule : rssd_top

//--- verilog/rssd_pkg.sv
// rssd_pkg: constants and state type of the reset sequencer
// assumes a 250 MHz system clock; detectors arrive as async pins
// Notes on behaviour
// RQ1: four sources each hold the core reset
// RQ2: reset pin low past 500 ns resets
// RQ3: pin driver holds low past 500 ns
// RQ4: watchdog resets only when enabled and expired
// RQ5: reset inits I/O; fetch starts at zero
// RQ6: select code picks 6, 16K or 1K clocks
// RQ7: real-time part counted in watchdog ticks
// RQ8: wake from sleep runs clock part only
// RQ9: power good starts delay, reset held meanwhile
// RQ10: power loss reasserts reset at once
// RQ11: pin rising edge starts the release delay
// RQ12: enabled brown-out asserts reset immediately
// RQ13: brown-out release uses the same delay
// RQ14: level fuse picks the trigger level
// RQ15: brown-out must persist 9 or 21 us
// RQ16: level fuse sets delays even detector off
// RQ17: watchdog reset pulse lasts one clock
// RQ18: delay starts after watchdog pulse falls
// RQ19: select code resets to 010
// RQ20: counter cleared while any source active
package rssd_pkg;
  localparam int CLK_MHZ     = 250;
  localparam int EXT_MIN_NS  = 500;
  localparam int EXT_FLT_CYC = (EXT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int BOD_HI_US   = 9;
  localparam int BOD_LO_US   = 21;
  localparam int BOD_HI_CYC  = BOD_HI_US * CLK_MHZ;
  localparam int BOD_LO_CYC  = BOD_LO_US * CLK_MHZ;
  localparam int CK_SHORT    = 6;
  localparam int CK_MID      = 1024;
  localparam int CK_LONG     = 16384;
  localparam int RT_LO_SHORT = 1024;
  localparam int RT_LO_LONG  = 16384;
  localparam int RT_HI_SHORT = 4096;
  localparam int RT_HI_LONG  = 65536;
  localparam int RT_BOD      = 16;
  localparam int CNT_W       = 17;
  localparam int EXT_W       = 8;
  localparam int BOD_W       = 13;
  localparam logic [2:0]  SEL_RESET = 3'h2;
  localparam logic [3:0]  CTRL_OFS  = 4'h0;
  localparam logic [3:0]  STAT_OFS  = 4'h4;
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_LVL     = 3;
  localparam int CTRL_BOD     = 4;
  localparam int CTRL_WDT     = 5;
  localparam int STAT_RST     = 0;
  localparam int STAT_STALL   = 1;
  localparam int STAT_FSM_LSB = 2;
  localparam int STAT_POR     = 5;
  localparam int STAT_EXT     = 6;
  localparam int STAT_WDT     = 7;
  localparam int STAT_BOD     = 8;
  localparam logic [15:0] BOOT_ADDR = 16'h0000;
  typedef enum logic [2:0] {
    ST_HOLD,
    ST_REAL,
    ST_CLOCK,
    ST_RUN,
    ST_WAKE
  } rssd_state_e;
endpackage : rssd_pkg

//--- test/rssd_far.sv
// rssd_far: pin driver, supply detectors, watchdog oscillator
// assumes one bench process calls its tasks at a time
module rssd_far (
  input  wire logic clk,         // system clock
  output logic      power_ok,    // supply above threshold
  output logic      ext_reset_n, // reset pin, low active
  output logic      bod_below,   // supply below trigger
  output logic      wdt_osc      // watchdog ticks
);
  timeunit 1ns;
  timeprecision 1ps;
  // supply starts low; pin idles high as if pulled up
  initial begin
    power_ok = 1'b0;
    ext_reset_n = 1'b1;
    bod_below = 1'b0;
    wdt_osc = 1'b0;
  end
  // free running, 4 clocks a period, off the clock edges
  initial begin
    #1;
    forever #8 wdt_osc = ~wdt_osc;
  end
  task automatic pin(input int n);
    @(posedge clk);
    ext_reset_n <= 1'b0;
    repeat (n) @(posedge clk);
    ext_reset_n <= 1'b1;
    @(negedge clk);
  endtask : pin
  // supply dip lasting n clocks
  task automatic bod(input int n);
    @(posedge clk);
    bod_below <= 1'b1;
    repeat (n) @(posedge clk);
    bod_below <= 1'b0;
    @(negedge clk);
  endtask : bod
  // supply above or below threshold
  task automatic pw(input logic v);
    @(posedge clk);
    power_ok <= v;
    @(negedge clk);
  endtask : pw
endmodule : rssd_far

//--- test/test_rssd_top.sv
// test_rssd_top: directed tests of reset merge and start-up delay
// assumes shortened long counts and a 4-clock watchdog tick
module test_rssd_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CKL = 20;
  localparam int RLL = 8;
  localparam int RHL = 12;
  localparam int BLC = 40;
  logic        clk = 1'b0;
  logic        rst;
  logic        clk_en;
  logic        wdt_timeout;
  logic        wake_req;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [3:0]  be = 4'hf;
  logic [31:0] avs_readdata, q;
  logic        avs_waitrequest, core_reset, io_init, core_stall, fetch_start;
  logic        power_ok, ext_reset_n, bod_below, wdt_osc;
  logic [15:0] boot_addr;
  int          failures = 0;
  int          check_count = 0;
  int          fs_cnt = 0;
  int          nrel = 0;
  int          n;

  rssd_far far (.clk, .power_ok, .ext_reset_n, .bod_below, .wdt_osc);

  rssd_top #(.CK_LONG_CYC(CKL), .RT_LO_LONG(RLL), .RT_HI_LONG(RHL), .BOD_LO_CYC(BLC)) uut (
    .clk, .rst, .clk_en, .power_ok, .ext_reset_n, .bod_below, .wdt_osc, .wdt_timeout,
    .wake_req, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .core_reset, .io_init, .core_stall, .fetch_start,
    .boot_addr
  );

  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end

  // release pulses seen on settled values
  always @(negedge clk) begin
    if (fetch_start === 1'b1) fs_cnt++;
  end

  // delay expected from select code and level fuse
  function automatic int exp_d(input int s, input bit l);
    int r;
    int c;
    c = (s < 2) ? rssd_pkg::CK_SHORT : (s < 5) ? CKL : rssd_pkg::CK_MID;
    r = (s % 3 == 2) ? (l ? RHL : RLL) : rssd_pkg::RT_BOD;
    if (s % 3 == 0) r = l ? rssd_pkg::RT_HI_SHORT : rssd_pkg::RT_LO_SHORT;
    return r * 4 + c;
  endfunction : exp_d

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp

  task automatic rng(input int g, input int lo, input int hi);
    check_count++;
    if (g < lo || g > hi) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
    end
  endtask : rng

  // held to the rising edge that sees waitrequest low, read data taken there
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(negedge clk);
  endtask : bus

  // cycles to release, then exactly one fetch pulse
  task automatic rel(input int e);
    n = 0;
    while (core_reset !== 1'b0 && n < 90000) begin
      @(negedge clk);
      n++;
    end
    rng(n, e - 4, e + 20);
    repeat (2) @(negedge clk);
    nrel++;
    cmp(fs_cnt, nrel);
  endtask : rel

  task automatic wdt;
    @(posedge clk);
    wdt_timeout <= 1'b1;
    @(posedge clk);
    wdt_timeout <= 1'b0;
    repeat (2) @(negedge clk);
  endtask : wdt

  task automatic done(input string s);
    $display("test %s done: %0d checks, %0d mismatches", s, check_count, failures);
  endtask : done

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // a hang counts as a mismatch
  initial begin
    #200000;
    failures++;
    end_of_test();
  end

  initial begin
    rst <= 1'b1;
    clk_en <= 1'b1;
    wdt_timeout <= 1'b0;
    wake_req <= 1'b0;
    avs_address <= 4'h0;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= 32'h0000_0000;
    avs_byteenable <= 4'hf;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    bus(0, rssd_pkg::CTRL_OFS, 0);
    cmp(q, {29'h0, rssd_pkg::SEL_RESET});
    cmp({16'h0, boot_addr}, {16'h0, rssd_pkg::BOOT_ADDR});
    cmp(io_init, 1'b1);
    bus(0, 4'hc, 0);
    cmp(q, 0);
    far.pw(1'b1);
    rel(exp_d(2, 0));
    be = 4'he;
    bus(1, rssd_pkg::CTRL_OFS, 32'h0000_0005);
    be = 4'hf;
    bus(0, rssd_pkg::CTRL_OFS, 0);
    cmp(q, 32'h0000_0002);
    done("power_up");
    for (int s = 0; s < 10; s++) begin
      bus(1, rssd_pkg::CTRL_OFS, (s < 8) ? s : (s - 7) | 8);
      far.pin(200);
      cmp(core_reset, 1'b1);
      rel((s < 8) ? exp_d(s, 0) : exp_d(s - 7, 1));
    end
    far.pin(100);
    repeat (10) @(negedge clk);
    cmp(core_reset, 1'b0);
    done("pin");
    wdt();
    cmp(core_reset, 1'b0);
    bus(1, rssd_pkg::CTRL_OFS, 32'h0000_0022);
    wdt();
    cmp(core_reset, 1'b1);
    rel(exp_d(2, 0));
    done("watchdog");
    bus(1, rssd_pkg::CTRL_OFS, 32'h0000_0012);
    far.bod(20);
    repeat (8) @(negedge clk);
    cmp(core_reset, 1'b0);
    far.bod(100);
    cmp(core_reset, 1'b1);
    rel(exp_d(2, 0));
    bus(1, rssd_pkg::CTRL_OFS, 32'h0000_001a);
    far.bod(100);
    repeat (8) @(negedge clk);
    cmp(core_reset, 1'b0);
    bus(1, rssd_pkg::CTRL_OFS, 32'h0000_0002);
    far.bod(200);
    repeat (8) @(negedge clk);
    cmp(core_reset, 1'b0);
    done("brownout");
    far.pw(1'b0);
    repeat (4) @(negedge clk);
    cmp(core_reset, 1'b1);
    far.pw(1'b1);
    rel(exp_d(2, 0));
    done("power_loss");
    @(posedge clk);
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    repeat (2) @(negedge clk);
    cmp(core_stall, 1'b1);
    n = 0;
    while (core_stall === 1'b1 && n < 999) begin
      @(negedge clk);
      n++;
    end
    rng(n, CKL - 4, CKL + 4);
    cmp(core_reset, 1'b0);
    cmp(fs_cnt, nrel);
    done("wake");
    // frozen enable: bus stalls and a wake strobe is not taken
    fork
      bus(0, rssd_pkg::STAT_OFS, 0);
      begin
        @(posedge clk);
        clk_en <= 1'b0;
        wake_req <= 1'b1;
        repeat (6) @(posedge clk);
        clk_en <= 1'b1;
        wake_req <= 1'b0;
      end
    join
    cmp(q, 32'h0000_000c);
    cmp(core_stall, 1'b0);
    done("freeze");
    end_of_test();
  end
endmodule : test_rssd_top
